/* File: core/match_hold_filter.sv */
// persistence filter: qualifies a condition held long enough
`timescale 1ns/10ps
module match_hold_filter (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       cond,
   output logic [2:0]      hold_cnt,
   output logic            qualified,
   output logic            rejected
);

   match_pkg::hold_state_t state_r;
   logic [2:0]             cnt_r;

   // =====================================================================
   // hold state machine and cycle counter
   // =====================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= match_pkg::HOLD_WAIT;
         cnt_r   <= 3'h0;
      end else begin
         case (state_r)
            match_pkg::HOLD_WAIT: begin
               if (cond) begin
                  state_r <= match_pkg::HOLD_COUNT;
                  cnt_r   <= 3'h1;
               end
            end
            match_pkg::HOLD_COUNT: begin
               if (!cond) begin
                  state_r <= match_pkg::HOLD_WAIT;  // too short, dropped
                  cnt_r   <= 3'h0;
               end else if (cnt_r == match_pkg::HOLD_CYCLES) begin
                  state_r <= match_pkg::HOLD_HELD;
               end else begin
                  cnt_r <= cnt_r + 3'h1;
               end
            end
            match_pkg::HOLD_HELD: begin
               if (!cond) begin
                  state_r <= match_pkg::HOLD_WAIT;
                  cnt_r   <= 3'h0;
               end
            end
            default: begin
               state_r <= match_pkg::HOLD_WAIT;
               cnt_r   <= 3'h0;
            end
         endcase
      end
   end

   // =====================================================================
   // outputs: qualified on the seventh consecutive cycle onward
   // =====================================================================
   assign hold_cnt  = cnt_r;
   assign qualified = cond && ((state_r == match_pkg::HOLD_HELD) ||
                               ((state_r == match_pkg::HOLD_COUNT) &&
                                (cnt_r == match_pkg::HOLD_CYCLES)));
   assign rejected  = !cond && (state_r == match_pkg::HOLD_COUNT);

endmodule : match_hold_filter

/* File: core/match_pkg.sv */
// shared constants, types and helpers of the port pattern match block
package match_pkg;

   // =====================================================================
   // register offsets
   // =====================================================================
   localparam logic [7:0] PIN_ENABLE_MASK_OFS = 8'h86;
   localparam logic [7:0] MATCH_PATTERN_OFS   = 8'h93;
   localparam logic [7:0] MATCH_CONTROL_OFS   = 8'h94;
   localparam logic [7:0] IRQ_ENABLE_OFS      = 8'h95;
   localparam logic [7:0] EVENT_STATUS_OFS    = 8'h96;
   localparam logic [7:0] EVENT_MASK_OFS      = 8'h97;

   // =====================================================================
   // field positions
   // =====================================================================
   localparam int CTRL_FLAG_BIT     = 0;  // match_flag in match_control
   localparam int CTRL_POLARITY_BIT = 1;  // match_polarity in match_control
   localparam int EN_MATCH_IRQ_BIT  = 0;  // match_irq_enable in irq_enable
   localparam int EN_GLOBAL_BIT     = 1;  // global_irq_enable in irq_enable
   localparam int EV_QUALIFIED_BIT  = 0;  // match condition qualified
   localparam int EV_REJECTED_BIT   = 1;  // match condition too short
   localparam int EV_WIDTH          = 2;

   // =====================================================================
   // reset values
   // =====================================================================
   localparam logic [7:0]          PIN_ENABLE_MASK_RST = 8'h00;
   localparam logic [7:0]          MATCH_PATTERN_RST   = 8'hff;
   localparam logic                MATCH_FLAG_RST      = 1'h0;
   localparam logic                MATCH_POLARITY_RST  = 1'h0;
   localparam logic [1:0]          IRQ_ENABLE_RST      = 2'h0;
   localparam logic [EV_WIDTH-1:0] EVENT_STATUS_RST    = 2'h0;
   localparam logic [EV_WIDTH-1:0] EVENT_MASK_RST      = 2'h0;

   // =====================================================================
   // timing: match must hold longer than this many cpu clock cycles
   // =====================================================================
   localparam logic [2:0] HOLD_CYCLES = 3'h6;
   localparam logic [3:0] RUN_CNT_MAX = 4'hf;

   // =====================================================================
   // types
   // =====================================================================
   typedef struct packed {
      logic       wr;     // one-cycle write strobe
      logic       rd;     // one-cycle read strobe
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [2:0] {
      HOLD_WAIT  = 3'b001,
      HOLD_COUNT = 3'b010,
      HOLD_HELD  = 3'b100
   } hold_state_t;

   // masked equality of port and pattern, pins with a zero mask bit ignored
   function automatic logic masked_equal(input logic [7:0] pins,
                                         input logic [7:0] pattern,
                                         input logic [7:0] mask);
      masked_equal = (((pins ^ pattern) & mask) == 8'h00);
   endfunction : masked_equal

endpackage : match_pkg

/* File: core/port_match_irq.sv */
// port pattern match interrupt block with register port
`timescale 1ns/10ps
module port_match_irq (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire match_pkg::reg_req_t req,
   output logic [7:0]               rd_data,
   input  wire logic [7:0]          port_pins,
   output logic                     port_match_interrupt,
   output logic                     wake_req
);

   // =====================================================================
   // registers and internal signals
   // =====================================================================
   logic [7:0]                    pin_enable_mask_r;
   logic [7:0]                    match_pattern_r;
   logic                          match_flag_r;
   logic                          match_flag_nxt;
   logic                          match_polarity_r;
   logic                          match_irq_enable_r;
   logic                          global_irq_enable_r;
   logic [match_pkg::EV_WIDTH-1:0] event_status_r;
   logic [match_pkg::EV_WIDTH-1:0] event_status_nxt;
   logic [match_pkg::EV_WIDTH-1:0] event_mask_r;
   logic [match_pkg::EV_WIDTH-1:0] event_set;
   logic [7:0]                    rd_data_r;
   logic [7:0]                    rd_data_nxt;
   logic                          irq_r;
   logic                          irq_nxt;
   logic                          wake_r;
   logic                          qualified_prev_r;
   logic                          function_active;
   logic                          pins_equal;
   logic                          match_cond;
   logic                          qualified;
   logic                          rejected;
   logic [2:0]                    hold_cnt;
   logic                          wr_mask;
   logic                          wr_pattern;
   logic                          wr_control;
   logic                          wr_irq_enable;
   logic                          wr_status;
   logic                          wr_event_mask;

   // =====================================================================
   // write decode
   // =====================================================================
   always_comb begin
      wr_mask       = 1'b0;
      wr_pattern    = 1'b0;
      wr_control    = 1'b0;
      wr_irq_enable = 1'b0;
      wr_status     = 1'b0;
      wr_event_mask = 1'b0;
      if (req.wr) begin
         if (req.addr == match_pkg::PIN_ENABLE_MASK_OFS) begin
            wr_mask = 1'b1;
         end else if (req.addr == match_pkg::MATCH_PATTERN_OFS) begin
            wr_pattern = 1'b1;
         end else if (req.addr == match_pkg::MATCH_CONTROL_OFS) begin
            wr_control = 1'b1;
         end else if (req.addr == match_pkg::IRQ_ENABLE_OFS) begin
            wr_irq_enable = 1'b1;
         end else if (req.addr == match_pkg::EVENT_STATUS_OFS) begin
            wr_status = 1'b1;
         end else if (req.addr == match_pkg::EVENT_MASK_OFS) begin
            wr_event_mask = 1'b1;
         end
      end
   end

   // =====================================================================
   // pin enable mask
   // =====================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_enable_mask_r <= match_pkg::PIN_ENABLE_MASK_RST;
      end else if (wr_mask) begin
         pin_enable_mask_r <= req.wdata;
      end
   end

   // =====================================================================
   // match pattern, bit n against pin n
   // =====================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         match_pattern_r <= match_pkg::MATCH_PATTERN_RST;
      end else if (wr_pattern) begin
         match_pattern_r <= req.wdata;
      end
   end

   // =====================================================================
   // polarity and interrupt enables
   // =====================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         match_polarity_r <= match_pkg::MATCH_POLARITY_RST;
      end else if (wr_control) begin
         match_polarity_r <= req.wdata[match_pkg::CTRL_POLARITY_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         match_irq_enable_r  <= match_pkg::IRQ_ENABLE_RST[match_pkg::EN_MATCH_IRQ_BIT];
         global_irq_enable_r <= match_pkg::IRQ_ENABLE_RST[match_pkg::EN_GLOBAL_BIT];
      end else if (wr_irq_enable) begin
         match_irq_enable_r  <= req.wdata[match_pkg::EN_MATCH_IRQ_BIT];
         global_irq_enable_r <= req.wdata[match_pkg::EN_GLOBAL_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         event_mask_r <= match_pkg::EVENT_MASK_RST;
      end else if (wr_event_mask) begin
         event_mask_r <= req.wdata[match_pkg::EV_WIDTH-1:0];
      end
   end

   // =====================================================================
   // match condition: masked compare with selectable polarity
   // =====================================================================
   assign function_active = |pin_enable_mask_r;  // no enabled pin, no match
   assign pins_equal      = match_pkg::masked_equal(port_pins, match_pattern_r,
                                                    pin_enable_mask_r);
   assign match_cond      = function_active &&
                            (match_polarity_r ? pins_equal : !pins_equal);

   // persistence filter on the match condition
   match_hold_filter u_hold (
      .clk       (clk),
      .rst_n     (rst_n),
      .cond      (match_cond),
      .hold_cnt  (hold_cnt),
      .qualified (qualified),
      .rejected  (rejected)
   );

   // =====================================================================
   // match flag: set by hardware, cleared by writing zero, set wins
   // =====================================================================
   always_comb begin
      match_flag_nxt = match_flag_r;
      if (wr_control && !req.wdata[match_pkg::CTRL_FLAG_BIT]) begin
         match_flag_nxt = 1'b0;
      end
      if (qualified) begin
         match_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         match_flag_r <= match_pkg::MATCH_FLAG_RST;
      end else begin
         match_flag_r <= match_flag_nxt;
      end
   end

   // =====================================================================
   // event status: sticky, write one to clear, set wins
   // =====================================================================
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         qualified_prev_r <= 1'b0;
      end else begin
         qualified_prev_r <= qualified;
      end
   end

   always_comb begin
      event_set                               = '0;
      event_set[match_pkg::EV_QUALIFIED_BIT]  = qualified && !qualified_prev_r;
      event_set[match_pkg::EV_REJECTED_BIT]   = rejected;
      event_status_nxt = event_status_r;
      if (wr_status) begin
         event_status_nxt = event_status_r & ~req.wdata[match_pkg::EV_WIDTH-1:0];
      end
      event_status_nxt = event_status_nxt | event_set;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         event_status_r <= match_pkg::EVENT_STATUS_RST;
      end else begin
         event_status_r <= event_status_nxt;
      end
   end

   // =====================================================================
   // single interrupt line and wake request
   // =====================================================================
   assign irq_nxt = global_irq_enable_r &&
                    ((match_flag_r && match_irq_enable_r) ||
                     (|(event_status_r & event_mask_r)));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= match_flag_r && match_irq_enable_r;
      end
   end

   // =====================================================================
   // read path, data one cycle after the strobe
   // =====================================================================
   always_comb begin
      rd_data_nxt = 8'h00;
      if (req.rd) begin
         if (req.addr == match_pkg::PIN_ENABLE_MASK_OFS) begin
            rd_data_nxt = pin_enable_mask_r;
         end else if (req.addr == match_pkg::MATCH_PATTERN_OFS) begin
            rd_data_nxt = match_pattern_r;
         end else if (req.addr == match_pkg::MATCH_CONTROL_OFS) begin
            rd_data_nxt = {6'h00, match_polarity_r, match_flag_r};
         end else if (req.addr == match_pkg::IRQ_ENABLE_OFS) begin
            rd_data_nxt = {6'h00, global_irq_enable_r, match_irq_enable_r};
         end else if (req.addr == match_pkg::EVENT_STATUS_OFS) begin
            rd_data_nxt = {6'h00, event_status_r};
         end else if (req.addr == match_pkg::EVENT_MASK_OFS) begin
            rd_data_nxt = {6'h00, event_mask_r};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_r <= 8'h00;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data              = rd_data_r;
   assign port_match_interrupt = irq_r;
   assign wake_req             = wake_r;

   // =====================================================================
   // checks
   // =====================================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // helper: consecutive cycles of the match condition
   logic [3:0] run_cnt_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_cnt_r <= 4'h0;
      end else if (!match_cond) begin
         run_cnt_r <= 4'h0;
      end else if (run_cnt_r != match_pkg::RUN_CNT_MAX) begin
         run_cnt_r <= run_cnt_r + 4'h1;
      end
   end

   sequence s_match_held;
      match_cond [*7];
   endsequence

   sequence s_flag_cleared;
      wr_control && !req.wdata[match_pkg::CTRL_FLAG_BIT] && !qualified;
   endsequence

   property p_flag_after_hold;
      s_match_held |=> match_flag_r;
   endproperty
   a_flag_after_hold: assert property (p_flag_after_hold)
      else $error("flag not set after match held seven cycles");

   property p_no_short_set;
      $rose(match_flag_r) |-> ($past(run_cnt_r) >= {1'b0, match_pkg::HOLD_CYCLES}) &&
         $past(match_cond) && ($past(hold_cnt) == match_pkg::HOLD_CYCLES);
   endproperty
   a_no_short_set: assert property (p_no_short_set)
      else $error("flag set by a match shorter than seven cycles");

   property p_flag_sticky;
      match_flag_r && !(wr_control && !req.wdata[match_pkg::CTRL_FLAG_BIT])
         |=> match_flag_r;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("flag dropped without a zero write");

   property p_flag_clear;
      s_flag_cleared |=> !match_flag_r ##1 (match_flag_r == $past(qualified));
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by zero write");

   property p_polarity_equal;
      match_polarity_r && function_active &&
         (((port_pins ^ match_pattern_r) & pin_enable_mask_r) == 8'h00) |-> match_cond;
   endproperty
   a_polarity_equal: assert property (p_polarity_equal)
      else $error("equal polarity did not match equal pins");

   property p_key_press;
      (match_pattern_r == 8'hff) && !match_polarity_r &&
         ((~port_pins & pin_enable_mask_r) != 8'h00) |-> match_cond;
   endproperty
   a_key_press: assert property (p_key_press)
      else $error("pressed key on enabled pin not matched");

   property p_masked_pins_ignored;
      (pin_enable_mask_r == 8'h00) |-> !match_cond;
   endproperty
   a_masked_pins_ignored: assert property (p_masked_pins_ignored)
      else $error("match with no pin enabled");

   property p_irq_gate;
      match_flag_r && match_irq_enable_r && global_irq_enable_r |=> irq_r;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("enabled flag did not raise interrupt");

   property p_irq_needs_global;
      !global_irq_enable_r |=> !irq_r;
   endproperty
   a_irq_needs_global: assert property (p_irq_needs_global)
      else $error("interrupt without global enable");

   property p_wake;
      match_flag_r && match_irq_enable_r |=> wake_req ##0 port_match_interrupt ==
         $past(global_irq_enable_r);
   endproperty
   a_wake: assert property (p_wake)
      else $error("enabled match did not request wake");

   property p_mask_reset;
      $past(!rst_n) |-> (pin_enable_mask_r == 8'h00) && (match_pattern_r == 8'hff);
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("mask or pattern wrong after reset");

   property p_pattern_read;
      req.rd && (req.addr == match_pkg::MATCH_PATTERN_OFS) |=>
         rd_data == $past(match_pattern_r);
   endproperty
   a_pattern_read: assert property (p_pattern_read)
      else $error("pattern read back wrong");

endmodule : port_match_irq

/* File: verif/keypad_model.sv */
// keypad model: keys pull port pins low, pull-ups hold them high
`timescale 1ns/10ps
module keypad_model (
   input  wire logic [7:0] key_down,
   output logic [7:0]      port_pins
);
   // =====================================================================
   // pins
   // =====================================================================
   // released key leaves its pin at the pull-up level
   assign port_pins = ~key_down;
endmodule : keypad_model

/* File: verif/testbench.sv */
// self-checking testbench of the port pattern match interrupt block
`timescale 1ns/10ps
module testbench;
   logic                clk;
   logic                rst_n;
   match_pkg::reg_req_t req;
   logic [7:0]          rd_data;
   logic [7:0]          port_pins;
   logic [7:0]          key_down;
   logic                port_match_interrupt;
   logic                wake_req;
   int                  n_fail;
   int                  n_compared;
   logic [7:0]          v;

   // =====================================================================
   // design and keypad
   // =====================================================================
   port_match_irq dut_u (
      .clk                  (clk),
      .rst_n                (rst_n),
      .req                  (req),
      .rd_data              (rd_data),
      .port_pins            (port_pins),
      .port_match_interrupt (port_match_interrupt),
      .wake_req             (wake_req)
   );
   keypad_model keys_u (
      .key_down  (key_down),
      .port_pins (port_pins)
   );

   // =====================================================================
   // helpers
   // =====================================================================
   // clock of 10 ns
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1 d = rd_data;
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      rd(a, v);
      chk(v, exp);
   endtask : rchk

   // keys held for n cycles, then released and settled
   task automatic press(input logic [7:0] k, input int n);
      @(posedge clk);
      key_down <= k;
      repeat (n) @(posedge clk);
      key_down <= 8'h00;
      repeat (3) @(posedge clk);
   endtask : press

   task automatic close_out;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // =====================================================================
   // scenarios
   // =====================================================================
   task automatic t_reset_and_map;
      rchk(match_pkg::PIN_ENABLE_MASK_OFS, 8'h00);
      rchk(match_pkg::MATCH_PATTERN_OFS, 8'hff);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h00);
      wr(match_pkg::MATCH_PATTERN_OFS, 8'h3c);
      rchk(match_pkg::MATCH_PATTERN_OFS, 8'h3c);
      wr(8'h50, 8'h77);
      rchk(8'h50, 8'h00);
      wr(match_pkg::MATCH_PATTERN_OFS, 8'hff);
      // no mask, no function: key press ignored
      press(8'hff, 10);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h00);
   endtask : t_reset_and_map

   task automatic t_hold_and_sticky;
      wr(match_pkg::PIN_ENABLE_MASK_OFS, 8'h01);
      press(8'h01, 6);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h00);
      rchk(match_pkg::EVENT_STATUS_OFS, 8'h02);
      wr(match_pkg::EVENT_STATUS_OFS, 8'hff);
      press(8'h01, 7);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h01);
      wr(match_pkg::MATCH_CONTROL_OFS, 8'h01);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h01);
      wr(match_pkg::MATCH_CONTROL_OFS, 8'h00);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h00);
      press(8'h02, 10);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h00);
   endtask : t_hold_and_sticky

   task automatic t_equal_polarity;
      wr(match_pkg::PIN_ENABLE_MASK_OFS, 8'hff);
      wr(match_pkg::MATCH_PATTERN_OFS, 8'ha5);
      wr(match_pkg::MATCH_CONTROL_OFS, 8'h02);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h02);
      press(8'h5b, 10);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h02);
      press(8'h5a, 7);
      rchk(match_pkg::MATCH_CONTROL_OFS, 8'h03);
      wr(match_pkg::MATCH_CONTROL_OFS, 8'h00);
      wr(match_pkg::MATCH_PATTERN_OFS, 8'hff);
      wr(match_pkg::PIN_ENABLE_MASK_OFS, 8'h01);
      wr(match_pkg::EVENT_STATUS_OFS, 8'hff);
   endtask : t_equal_polarity

   task automatic t_interrupt;
      wr(match_pkg::IRQ_ENABLE_OFS, 8'h01);
      press(8'h01, 7);
      #1 chk({7'h00, port_match_interrupt}, 8'h00);
      chk({7'h00, wake_req}, 8'h01);
      wr(match_pkg::IRQ_ENABLE_OFS, 8'h03);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, port_match_interrupt}, 8'h01);
      wr(match_pkg::EVENT_MASK_OFS, 8'h01);
      wr(match_pkg::MATCH_CONTROL_OFS, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, wake_req}, 8'h00);
      chk({7'h00, port_match_interrupt}, 8'h01);
      rchk(match_pkg::EVENT_STATUS_OFS, 8'h01);
      wr(match_pkg::EVENT_STATUS_OFS, 8'h01);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, port_match_interrupt}, 8'h00);
      rchk(match_pkg::EVENT_STATUS_OFS, 8'h00);
   endtask : t_interrupt

   // =====================================================================
   // main sequence and watchdog
   // =====================================================================
   initial begin
      n_fail     = 0;
      n_compared = 0;
      rst_n      = 1'b0;
      req        = '0;
      key_down   = 8'h00;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_and_map;
      t_hold_and_sticky;
      t_equal_polarity;
      t_interrupt;
      close_out;
   end

   // the tests take well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      close_out;
   end
endmodule : testbench
